// *** hw/pps_regs.svh ***
// Constants for the PROM program sequencer: characters, counts, lengths
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// Teletype characters
`define PPS_CH_START_PGM 8'h53
`define PPS_CH_RESUME 8'h50
`define PPS_CH_LIST 8'h4C
`define PPS_CH_FIELD_B 8'h42
`define PPS_CH_FIELD_F 8'h46
`define PPS_CH_HIGH 8'h50
`define PPS_CH_LOW 8'h4E
`define PPS_CH_ERASE 8'h2F
`define PPS_CH_RUBOUT 8'h7F
`define PPS_CH_STAR 8'h2A
`define PPS_CH_DOLLAR 8'h24
`define PPS_CH_QUERY 8'h3F
`define PPS_CH_SPACE 8'h20
`define PPS_CH_SEMI 8'h3B
`define PPS_CH_ZERO 8'h30
`define PPS_CH_NINE 8'h39

// Counts and lengths
`define PPS_BITS_PER_WORD 4'h8
`define PPS_MAX_RETRY 3'h4
`define PPS_ADDR_DIGITS 2'h3
`define PPS_ADDR_LIMIT 10'h0FF
`define PPS_LEN_CHAR 4'h0
`define PPS_LEN_ADDR 4'h2
`define PPS_LEN_LINE 4'hF
`define PPS_ERASED_WORD 8'hFF

`endif

// *** hw/pps_pkg.sv ***
// Types shared by the PROM program sequencer files
`default_nettype none
package pps_pkg;
    // Sequencer states, Gray coded along command, program and verify path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_WORD = 4'h3,
        ST_PGM = 4'h2,
        ST_PWAIT = 4'h6,
        ST_READ1 = 4'h7,
        ST_READ2 = 4'h5,
        ST_VERIFY = 4'h4,
        ST_PRINT = 4'hC,
        ST_LCAP = 4'hD,
        ST_LNEXT = 4'hF,
        ST_TAPE = 4'hE,
        ST_FAIL = 4'hA
    } pps_state_t;

    // What the printer is emitting
    typedef enum logic [1:0] {
        PK_CHAR = 2'h0,
        PK_ADDR = 2'h1,
        PK_LINE = 2'h2
    } pps_kind_t;

    // Active command
    typedef enum logic [1:0] {
        CM_START = 2'h0,
        CM_RESUME = 2'h1,
        CM_LIST = 2'h2
    } pps_cmd_t;
endpackage
`default_nettype wire

// *** hw/pps_field_parser.sv ***
// Data word field parser: start marker, eight bit letters, stop marker
`default_nettype none
`include "pps_regs.svh"
module pps_field_parser (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_take,
    input wire logic [7:0] i_char,
    output logic o_word_valid,
    output logic [7:0] o_word,
    output logic o_fmt_err
);
    logic in_field_q, in_field_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sr_q, sr_d;
    logic valid_q, valid_d;
    logic err_q, err_d;
    logic [7:0] word_q, word_d;

    // Next-state of the field recogniser
    always_comb
    begin
        in_field_d = in_field_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        valid_d = 1'b0;
        err_d = 1'b0;
        word_d = word_q;
        if (i_take)
        begin
            if (i_char == `PPS_CH_FIELD_B)
            begin
                // A fresh start marker discards a half typed field
                in_field_d = 1'b1;
                cnt_d = 4'h0;
            end
            else if (in_field_q && i_char != `PPS_CH_RUBOUT)
            begin
                if ((i_char == `PPS_CH_HIGH || i_char == `PPS_CH_LOW)
                    && cnt_q != `PPS_BITS_PER_WORD)
                begin
                    sr_d = {sr_q[6:0], i_char == `PPS_CH_HIGH};
                    cnt_d = cnt_q + 4'h1;
                end
                else if (i_char == `PPS_CH_ERASE && cnt_q != 4'h0)
                begin
                    sr_d = {1'b0, sr_q[7:1]};
                    cnt_d = cnt_q - 4'h1;
                end
                else if (i_char == `PPS_CH_FIELD_F && cnt_q == `PPS_BITS_PER_WORD)
                begin
                    in_field_d = 1'b0;
                    valid_d = 1'b1;
                    word_d = sr_q;
                end
                else
                begin
                    // Anything else inside a field is malformed
                    in_field_d = 1'b0;
                    err_d = 1'b1;
                end
            end
        end
    end

    // Parser registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            in_field_q <= 1'b0;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            valid_q <= 1'b0;
            err_q <= 1'b0;
            word_q <= 8'h00;
        end
        else
        begin
            in_field_q <= in_field_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            valid_q <= valid_d;
            err_q <= err_d;
            word_q <= word_d;
        end
    end

    assign o_word_valid = valid_q;
    assign o_word = word_q;
    assign o_fmt_err = err_q;
endmodule // pps_field_parser
`default_nettype wire

// *** hw/pps_sequencer.sv ***
// PROM program sequencer: commands, programming, verify, retry and listing
// Notes on behaviour
// - Start command programs only locations between initial and final address.
// - Complete tape: words before the initial address are discarded.
// - Short tape: words go to consecutive locations from initial address.
// - First malformed word halts programming and prints its address.
// - Tape mode keeps reading after format error, printing each bad address.
// - Each programmed location is read back, compared, reprogrammed on mismatch.
// - At most four reprogrammings per location, a dollar printed for each.
// - Mismatch after fourth reprogramming stops everything and prints question mark.
// - First programmed word marked with asterisk; F printed when range done.
// - List command prints each word of range with its address, then F.
// - Erased bits list as the high letter.
// - Input inversion option complements data written to the PROM.
// - Output inversion option complements data read from the PROM.
// - Read-back disabled releases controller lines, which then read all ones.
// - A field is start marker, eight bit letters, stop marker; else error.
// - High letter gives high level, first letter is the top bit.
`default_nettype none
`include "pps_regs.svh"
module pps_sequencer (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_CHAR,
    output logic O_RX_READY,
    output logic O_TX_VALID,
    output logic [7:0] O_TX_CHAR,
    input wire logic I_TX_READY,
    input wire logic I_TAPE_MODE,
    input wire logic I_DIN_INV,
    input wire logic I_DOUT_INV,
    input wire logic I_DOUT_EN,
    output logic [7:0] O_PROM_ADDR,
    output logic [7:0] O_PROM_DATA,
    output logic O_PROM_PGM,
    input wire logic I_PROM_PGM_DONE,
    input wire logic [7:0] I_PROM_RDATA,
    output logic [7:0] O_CTL_RDATA,
    output logic O_BUSY,
    output logic O_FAIL
);
    pps_pkg::pps_state_t st_q, st_d, ret_q, ret_d;
    pps_pkg::pps_kind_t kind_q, kind_d;
    pps_pkg::pps_cmd_t cmd_q, cmd_d;
    logic [3:0] idx_q, idx_d;
    logic [7:0] mark_q, mark_d;
    logic [1:0] dig_q, dig_d;
    logic fin_q, fin_d;
    logic [9:0] acc_q, acc_d;
    logic [7:0] init_q, init_d, final_q, final_d, addr_q, addr_d;
    logic [7:0] word_q, word_d, pdata_q, pdata_d, ctl_q, ctl_d;
    logic pgm_q, pgm_d, first_q, first_d;
    logic [2:0] retry_q, retry_d;
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_char_q, tx_char_d;
    logic take, p_valid, p_err;
    logic [7:0] p_word;
    logic tx_free;
    logic [3:0] last_idx;
    logic [9:0] acc_next;

    // Field parser sees characters only while a data word is awaited
    pps_field_parser u_parser (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_take(take),
        .i_char(I_RX_CHAR),
        .o_word_valid(p_valid),
        .o_word(p_word),
        .o_fmt_err(p_err)
    );

    // --------------------------------------------------------------
    // Printer character selection
    // --------------------------------------------------------------
    function automatic logic [7:0] dec_digit(input logic [7:0] v, input logic [1:0] pos);
        logic [7:0] d;
        d = 8'h00;
        case (pos)
            2'h0: d = v / 8'd100;
            2'h1: d = (v / 8'd10) % 8'd10;
            default: d = v % 8'd10;
        endcase
        return `PPS_CH_ZERO + d;
    endfunction

    function automatic logic [7:0] char_at(input pps_pkg::pps_kind_t k, input logic [3:0] i,
        input logic [7:0] m, input logic [7:0] a, input logic [7:0] w);
        logic [7:0] c;
        c = m;
        if (k != pps_pkg::PK_CHAR)
        begin
            if (i < 4'h3)
                c = dec_digit(a, i[1:0]);
            else if (i == 4'h3 || i == 4'hF)
                c = `PPS_CH_SPACE;
            else if (i == 4'h4)
                c = `PPS_CH_FIELD_B;
            else if (i == 4'hE)
                c = `PPS_CH_SEMI;
            else if (i == 4'hD)
                c = `PPS_CH_FIELD_F;
            else
                // Bit letters, top bit first; an erased one reads as high
                c = w[3'(4'hC - i)] ? `PPS_CH_HIGH : `PPS_CH_LOW;
        end
        return c;
    endfunction

    assign tx_free = !tx_valid_q || I_TX_READY;
    assign last_idx = (kind_q == pps_pkg::PK_CHAR) ? `PPS_LEN_CHAR :
        (kind_q == pps_pkg::PK_ADDR) ? `PPS_LEN_ADDR : `PPS_LEN_LINE;
    assign O_RX_READY = (st_q == pps_pkg::ST_IDLE) || (st_q == pps_pkg::ST_ADDR)
        || (st_q == pps_pkg::ST_WORD) || (st_q == pps_pkg::ST_TAPE);
    assign take = I_RX_VALID && O_RX_READY
        && (st_q == pps_pkg::ST_WORD || st_q == pps_pkg::ST_TAPE);
    assign acc_next = 10'((acc_q * 10'd10) + {2'b00, I_RX_CHAR - `PPS_CH_ZERO});

    // --------------------------------------------------------------
    // Next-state logic of the whole sequencer
    // --------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        ret_d = ret_q;
        kind_d = kind_q;
        cmd_d = cmd_q;
        idx_d = idx_q;
        mark_d = mark_q;
        dig_d = dig_q;
        fin_d = fin_q;
        acc_d = acc_q;
        init_d = init_q;
        final_d = final_q;
        addr_d = addr_q;
        word_d = word_q;
        pdata_d = pdata_q;
        pgm_d = 1'b0;
        first_d = first_q;
        retry_d = retry_q;
        tx_valid_d = tx_valid_q && !I_TX_READY;
        tx_char_d = tx_char_q;
        // Read-back path, released lines float high
        ctl_d = !I_DOUT_EN ? `PPS_ERASED_WORD :
            (I_DOUT_INV ? ~I_PROM_RDATA : I_PROM_RDATA);
        case (st_q)
            pps_pkg::ST_IDLE:
            begin
                if (I_RX_VALID)
                begin
                    st_d = pps_pkg::ST_ADDR;
                    dig_d = 2'h0;
                    fin_d = 1'b0;
                    acc_d = 10'h000;
                    if (I_RX_CHAR == `PPS_CH_START_PGM)
                        cmd_d = pps_pkg::CM_START;
                    else if (I_RX_CHAR == `PPS_CH_RESUME)
                        cmd_d = pps_pkg::CM_RESUME;
                    else if (I_RX_CHAR == `PPS_CH_LIST)
                        cmd_d = pps_pkg::CM_LIST;
                    else
                        st_d = pps_pkg::ST_IDLE;
                end
            end
            pps_pkg::ST_ADDR:
            begin
                // Only digits count; separators and line ends are skipped
                if (I_RX_VALID && I_RX_CHAR >= `PPS_CH_ZERO && I_RX_CHAR <= `PPS_CH_NINE)
                begin
                    acc_d = acc_next;
                    dig_d = dig_q + 2'h1;
                    if (dig_q == `PPS_ADDR_DIGITS - 2'h1)
                    begin
                        dig_d = 2'h0;
                        acc_d = 10'h000;
                        fin_d = 1'b1;
                        if (!fin_q)
                            init_d = acc_next[7:0];
                        else
                            final_d = acc_next[7:0];
                        if (acc_next > `PPS_ADDR_LIMIT
                            || (fin_q && acc_next[7:0] < init_q))
                        begin
                            // Bad range: refuse the command
                            mark_d = `PPS_CH_QUERY;
                            kind_d = pps_pkg::PK_CHAR;
                            idx_d = 4'h0;
                            ret_d = pps_pkg::ST_IDLE;
                            st_d = pps_pkg::ST_PRINT;
                        end
                        else if (fin_q)
                        begin
                            first_d = 1'b1;
                            // Complete tape counts from zero, short tape from start
                            addr_d = (cmd_q == pps_pkg::CM_START) ? 8'h00 : init_q;
                            st_d = (cmd_q == pps_pkg::CM_LIST) ? pps_pkg::ST_READ1
                                : pps_pkg::ST_WORD;
                            if (cmd_q == pps_pkg::CM_LIST)
                                addr_d = init_q;
                        end
                    end
                end
            end
            pps_pkg::ST_WORD:
            begin
                if (p_err)
                begin
                    // Halt programming, report where the bad field landed
                    kind_d = pps_pkg::PK_ADDR;
                    idx_d = 4'h0;
                    ret_d = (I_TAPE_MODE && addr_q != final_q) ? pps_pkg::ST_TAPE
                        : pps_pkg::ST_IDLE;
                    st_d = pps_pkg::ST_PRINT;
                end
                else if (p_valid)
                begin
                    if (addr_q < init_q)
                        addr_d = addr_q + 8'h01;
                    else
                    begin
                        word_d = p_word;
                        pdata_d = I_DIN_INV ? ~p_word : p_word;
                        retry_d = 3'h0;
                        st_d = pps_pkg::ST_PGM;
                        if (first_q)
                        begin
                            first_d = 1'b0;
                            mark_d = `PPS_CH_STAR;
                            kind_d = pps_pkg::PK_CHAR;
                            idx_d = 4'h0;
                            ret_d = pps_pkg::ST_PGM;
                            st_d = pps_pkg::ST_PRINT;
                        end
                    end
                end
            end
            pps_pkg::ST_PGM:
            begin
                pgm_d = 1'b1;
                st_d = pps_pkg::ST_PWAIT;
            end
            pps_pkg::ST_PWAIT:
            begin
                if (I_PROM_PGM_DONE)
                    st_d = pps_pkg::ST_READ1;
            end
            pps_pkg::ST_READ1:
                st_d = pps_pkg::ST_READ2;
            pps_pkg::ST_READ2:
                // Two cycles let the read-back register follow the address
                st_d = (cmd_q == pps_pkg::CM_LIST) ? pps_pkg::ST_LCAP : pps_pkg::ST_VERIFY;
            pps_pkg::ST_VERIFY:
            begin
                kind_d = pps_pkg::PK_CHAR;
                idx_d = 4'h0;
                st_d = pps_pkg::ST_PRINT;
                if (ctl_q != word_q)
                begin
                    if (retry_q == `PPS_MAX_RETRY)
                    begin
                        mark_d = `PPS_CH_QUERY;
                        ret_d = pps_pkg::ST_FAIL;
                    end
                    else
                    begin
                        retry_d = retry_q + 3'h1;
                        mark_d = `PPS_CH_DOLLAR;
                        ret_d = pps_pkg::ST_PGM;
                    end
                end
                else if (addr_q == final_q)
                begin
                    mark_d = `PPS_CH_FIELD_F;
                    ret_d = pps_pkg::ST_IDLE;
                end
                else
                begin
                    addr_d = addr_q + 8'h01;
                    st_d = pps_pkg::ST_WORD;
                end
            end
            pps_pkg::ST_LCAP:
            begin
                word_d = ctl_q;
                kind_d = pps_pkg::PK_LINE;
                idx_d = 4'h0;
                ret_d = pps_pkg::ST_LNEXT;
                st_d = pps_pkg::ST_PRINT;
            end
            pps_pkg::ST_LNEXT:
            begin
                if (addr_q == final_q)
                begin
                    mark_d = `PPS_CH_FIELD_F;
                    kind_d = pps_pkg::PK_CHAR;
                    idx_d = 4'h0;
                    ret_d = pps_pkg::ST_IDLE;
                    st_d = pps_pkg::ST_PRINT;
                end
                else
                begin
                    addr_d = addr_q + 8'h01;
                    st_d = pps_pkg::ST_READ1;
                end
            end
            pps_pkg::ST_TAPE:
            begin
                // Tape runs on with the PROM untouched; bad fields still reported
                if (p_err || p_valid)
                begin
                    addr_d = addr_q + 8'h01;
                    if (p_err)
                    begin
                        kind_d = pps_pkg::PK_ADDR;
                        idx_d = 4'h0;
                        ret_d = pps_pkg::ST_TAPE;
                        st_d = pps_pkg::ST_PRINT;
                    end
                    if (addr_q + 8'h01 == final_q) // Field just read was the last
                    begin
                        ret_d = pps_pkg::ST_IDLE;
                        st_d = p_err ? pps_pkg::ST_PRINT : pps_pkg::ST_IDLE;
                    end
                end
            end
            pps_pkg::ST_PRINT:
            begin
                if (tx_free)
                begin
                    tx_valid_d = 1'b1;
                    tx_char_d = char_at(kind_q, idx_q, mark_q, addr_q, word_q);
                    idx_d = idx_q + 4'h1;
                    if (idx_q == last_idx)
                        st_d = ret_q;
                end
            end
            pps_pkg::ST_FAIL:
                st_d = pps_pkg::ST_FAIL; // Only a reset leaves here
            default:
                st_d = pps_pkg::ST_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            st_q <= pps_pkg::ST_IDLE;
            ret_q <= pps_pkg::ST_IDLE;
            kind_q <= pps_pkg::PK_CHAR;
            cmd_q <= pps_pkg::CM_START;
            idx_q <= 4'h0;
            mark_q <= 8'h00;
            dig_q <= 2'h0;
            fin_q <= 1'b0;
            acc_q <= 10'h000;
            init_q <= 8'h00;
            final_q <= 8'h00;
            addr_q <= 8'h00;
            word_q <= 8'h00;
            pdata_q <= 8'h00;
            ctl_q <= 8'h00;
            pgm_q <= 1'b0;
            first_q <= 1'b0;
            retry_q <= 3'h0;
            tx_valid_q <= 1'b0;
            tx_char_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            ret_q <= ret_d;
            kind_q <= kind_d;
            cmd_q <= cmd_d;
            idx_q <= idx_d;
            mark_q <= mark_d;
            dig_q <= dig_d;
            fin_q <= fin_d;
            acc_q <= acc_d;
            init_q <= init_d;
            final_q <= final_d;
            addr_q <= addr_d;
            word_q <= word_d;
            pdata_q <= pdata_d;
            ctl_q <= ctl_d;
            pgm_q <= pgm_d;
            first_q <= first_d;
            retry_q <= retry_d;
            tx_valid_q <= tx_valid_d;
            tx_char_q <= tx_char_d;
        end
    end

    // Outputs, all from flip-flops except ready, busy and fail, decoded from the state
    assign O_TX_VALID = tx_valid_q;
    assign O_TX_CHAR = tx_char_q;
    assign O_PROM_ADDR = addr_q;
    assign O_PROM_DATA = pdata_q;
    assign O_PROM_PGM = pgm_q;
    assign O_CTL_RDATA = ctl_q;
    assign O_BUSY = st_q != pps_pkg::ST_IDLE;
    assign O_FAIL = st_q == pps_pkg::ST_FAIL;
endmodule // pps_sequencer
`default_nettype wire

// *** dv/pps_sequencer_properties.sv ***
// Port assertions for the PROM program sequencer
`default_nettype none
module pps_seq_chk (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_TX_READY,
    input wire logic I_DOUT_EN,
    input wire logic I_DOUT_INV,
    input wire logic [7:0] I_PROM_RDATA,
    input wire logic [7:0] O_CTL_RDATA,
    input wire logic O_TX_VALID,
    input wire logic [7:0] O_TX_CHAR,
    input wire logic O_PROM_PGM,
    input wire logic [7:0] O_PROM_ADDR,
    input wire logic [7:0] O_PROM_DATA,
    input wire logic O_RX_READY,
    input wire logic O_FAIL
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_ARST_N);
    a_pgm_pulse_short: assert property (O_PROM_PGM |=> !O_PROM_PGM)
        else $error("program pulse longer than one cycle");
    a_pgm_word_held: assert property (O_PROM_PGM |=>
        ($stable(O_PROM_ADDR) && $stable(O_PROM_DATA)) [*2])
        else $error("address or data moved during programming");
    a_pgm_no_input: assert property (O_PROM_PGM |-> !O_RX_READY)
        else $error("input taken while programming");
    a_fail_sticky: assert property (O_FAIL |=> O_FAIL)
        else $error("failure flag dropped without reset");
    a_fail_halts: assert property (O_FAIL |-> !O_PROM_PGM && !O_RX_READY)
        else $error("activity after location failure");
    a_print_held: assert property (O_TX_VALID && !I_TX_READY |=>
        O_TX_VALID && $stable(O_TX_CHAR))
        else $error("printer character not held");
    a_readback_off: assert property (!I_DOUT_EN |=> O_CTL_RDATA == 8'hFF)
        else $error("released read-back lines not high");
    a_readback_inv: assert property (I_DOUT_EN |=> O_CTL_RDATA ==
        ($past(I_DOUT_INV) ? ~$past(I_PROM_RDATA) : $past(I_PROM_RDATA)))
        else $error("read-back data wrong");
endmodule // pps_seq_chk
`default_nettype wire

// *** dv/pps_prom_model.sv ***
// Behavioural PROM with program handshake and forced write drops
`default_nettype none
module pps_prom_model #(
    parameter int DLY = 2
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_pgm,
    input wire logic [3:0] i_fail_n,
    output logic o_done,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];
    int nw;
    int cnt;
    // Fresh part reads erased; contents survive a system reset
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    assign o_rdata = mem[i_addr];
    // First i_fail_n writes after reset are lost, to force retries
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            nw <= 0;
            cnt <= 0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= (cnt == 1);
            cnt <= i_pgm ? DLY : (cnt > 0 ? cnt - 1 : 0);
            if (i_pgm) nw <= nw + 1;
            if (i_pgm && nw >= i_fail_n) mem[i_addr] <= i_data;
        end
    end
endmodule // pps_prom_model
`default_nettype wire

// *** dv/pps_sequencer_test.sv ***
// Self-checking bench for the PROM program sequencer
`default_nettype none
module pps_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_v = 1'b0;
    logic tx_rdy = 1'b0;
    logic tape = 1'b0;
    logic din_inv = 1'b0;
    logic dout_inv = 1'b0;
    logic dout_en = 1'b1;
    logic [7:0] rx_c = 8'h00;
    logic [3:0] fail_n = 4'h0;
    logic rx_rdy, tx_v, pgm, done, busy, fail;
    logic [7:0] tx_c, p_addr, p_data, p_rd, ctl_rd, last_data;
    logic [7:0] txq[$];
    int n_fail = 0;
    int num_checks = 0;
    // Printer stalls every other cycle so held characters get exercised
    always #25 clk = ~clk;
    always @(posedge clk) tx_rdy <= ~tx_rdy;
    // Collect printout and the last word sent to the part
    always @(posedge clk)
    begin
        if (tx_v && tx_rdy) txq.push_back(tx_c);
        if (pgm) last_data <= p_data;
    end
    pps_sequencer dut (.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_RX_VALID(rx_v), .I_RX_CHAR(rx_c),
        .O_RX_READY(rx_rdy), .O_TX_VALID(tx_v), .O_TX_CHAR(tx_c), .I_TX_READY(tx_rdy),
        .I_TAPE_MODE(tape), .I_DIN_INV(din_inv), .I_DOUT_INV(dout_inv), .I_DOUT_EN(dout_en),
        .O_PROM_ADDR(p_addr), .O_PROM_DATA(p_data), .O_PROM_PGM(pgm), .I_PROM_PGM_DONE(done),
        .I_PROM_RDATA(p_rd), .O_CTL_RDATA(ctl_rd), .O_BUSY(busy), .O_FAIL(fail));
    pps_prom_model #(.DLY(3)) prom (.i_clk(clk), .i_arst_n(rst_n), .i_addr(p_addr),
        .i_data(p_data), .i_pgm(pgm), .i_fail_n(fail_n), .o_done(done), .o_rdata(p_rd));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each character held until taken; a stuck input counts as a hang
    task automatic send(string s);
        int k;
        for (int i = 0; i < s.len(); i++)
        begin
            rx_c <= s[i];
            rx_v <= 1'b1;
            k = 0;
            do @(negedge clk); while (!rx_rdy && ++k < 4000);
            if (k >= 4000) begin n_fail++; report_and_stop(); end
            @(posedge clk);
        end
        rx_v <= 1'b0;
        @(posedge clk);
    endtask
    // Wait for the printout, then allow a few cycles to catch extras
    task automatic expect_tx(string s);
        int k = 0;
        while (txq.size() < s.len() && k < 20000) begin @(posedge clk); k++; end
        if (k >= 20000) begin n_fail++; report_and_stop(); end
        repeat (4) @(posedge clk);
        check("tx count", 8'(s.len()), 8'(txq.size()));
        for (int i = 0; i < s.len(); i++) check("tx char", s[i], txq[i]);
        txq.delete();
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        txq.delete();
    endtask
    task automatic t_start();
        send("S001002BNNNNNNNNF\015BPNNNNNNNF\015BNPPPPPPPF\015");
        expect_tx("*F");
        check("last word", 8'h7F, last_data);
        send("L000003");
        expect_tx({"000 BPPPPPPPPF; 001 BPNNNNNNNF; ",
            "002 BNPPPPPPPF; 003 BPPPPPPPPF; F"});
        $display("test start done");
    endtask
    task automatic t_resume();
        din_inv <= 1'b1;
        dout_inv <= 1'b1;
        tape <= 1'b1;
        send("P010011BPPPPNNNNFBNNNNNNNPF");
        expect_tx("*F");
        check("inverted word", 8'hFE, last_data);
        din_inv <= 1'b0;
        dout_inv <= 1'b0;
        tape <= 1'b0;
        send("L010011");
        expect_tx("010 BNNNNPPPPF; 011 BPPPPPPPNF; F");
        $display("test resume done");
    endtask
    task automatic t_fmt();
        send("P020021BPPPPPPPXF");
        expect_tx("020");
        send("P020021BNNNNNNNNF\015BNNNNNNNNF\015");
        expect_tx("*F");
        tape <= 1'b1;
        send("P030031BPPPPPPPXFBPPPPPPPXF");
        expect_tx("030031");
        tape <= 1'b0;
        send("L030031");
        expect_tx("030 BPPPPPPPPF; 031 BPPPPPPPPF; F");
        dout_en <= 1'b0;
        repeat (2) @(negedge clk);
        check("released lines", 8'hFF, ctl_rd);
        @(posedge clk);
        dout_en <= 1'b1;
        $display("test format done");
    endtask
    task automatic t_retry();
        do_reset();
        fail_n <= 4'h4;
        send("P040040BNNNNNNNNF");
        expect_tx("*$$$$F");
        do_reset();
        fail_n <= 4'h5;
        send("P041041BNNNNNNNNF");
        expect_tx("*$$$$?");
        check("fail flag", 8'h01, {7'h00, fail});
        do_reset();
        check("fail cleared", 8'h00, {7'h00, fail});
        check("busy after reset", 8'h00, {7'h00, busy});
        $display("test retry done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_start();
        t_resume();
        t_fmt();
        t_retry();
        report_and_stop();
    end
endmodule // pps_sequencer_test
bind pps_sequencer pps_seq_chk chk (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N),
    .I_TX_READY(I_TX_READY), .I_DOUT_EN(I_DOUT_EN), .I_DOUT_INV(I_DOUT_INV),
    .I_PROM_RDATA(I_PROM_RDATA), .O_CTL_RDATA(O_CTL_RDATA), .O_TX_VALID(O_TX_VALID),
    .O_TX_CHAR(O_TX_CHAR), .O_PROM_PGM(O_PROM_PGM), .O_PROM_ADDR(O_PROM_ADDR),
    .O_PROM_DATA(O_PROM_DATA), .O_RX_READY(O_RX_READY), .O_FAIL(O_FAIL));
`default_nettype wire
